//--- rtl/lrs_status.sv
// Notes on behaviour
// - interrupt when any enabled flag is set
// - write one clears flag; reset clears all
// - packet ready set when packet stored
// - packet ready reasserts while packets remain
// - read error on read unanswered 2.15 us
// - dma end set on dma end-of-process
// - dma end clears when both dma enables clear
// - dma end meaningless in pc card mode
// - remote reset on length 0900, enabled, physical
// - no remote reset on multicast or broadcast
// - no remote reset while short accept enabled
// - remote reset clears at next packet start
// - short packet at most 60 bytes, no self-collision
// - crc error; alignment when also non-octet count
// - overflow on discard, never in loopback
// - new packet clears short, align, crc, overflow
//
// The placing of the registers and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module lrs_status
  import lrs_pkg::*;
#(
  parameter int RD_TMO_CYC = LRS_RD_TMO_CYC
)
(
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        ce,
  // axi4-lite slave
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // receive events, same clock domain
  input  wire logic        pkt_stored,
  input  wire logic        pkts_remaining,
  input  wire logic        host_rd_req,
  input  wire logic        host_rd_rdy,
  input  wire logic        dma_end_flag,
  input  wire logic        rx_start,
  input  wire logic        rx_done,
  input  wire logic        rx_phys_match,
  input  wire logic [15:0] rx_len_field,
  input  wire logic [10:0] rx_byte_count,
  input  wire logic        rx_self_collision,
  input  wire logic        rx_crc_bad,
  input  wire logic        rx_bits_odd,
  input  wire logic        rx_discarded,
  output logic             irq
);

  logic [7:0] flags;
  logic [7:0] irq_en_q;
  logic [3:0] mode_q;
  logic [1:0] dma_ctl_q;
  logic [7:0] set_ev;
  logic [7:0] clr_ev;
  logic [7:0] w1c;
  logic       rd_tmo;

  // write channel: address and data taken in either order
  logic        aw_held_q;
  logic        w_held_q;
  logic [3:0]  awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        wr_go;

  assign wr_go = aw_held_q && w_held_q && !s_axi_bvalid;

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      aw_held_q     <= 1'b0;
      w_held_q      <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      awaddr_q      <= 4'h0;
      wdata_q       <= 32'h0000_0000;
      wstrb_q       <= 4'h0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= LRS_RESP_OKAY;
    end
    else if (ce)
    begin
      s_axi_awready <= !aw_held_q && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_held_q && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end
      if (wr_go)
      begin
        aw_held_q    <= 1'b0;
        w_held_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (awaddr_q == LRS_ADDR_STATUS || awaddr_q == LRS_ADDR_IRQ_EN ||
            awaddr_q == LRS_ADDR_MODE || awaddr_q == LRS_ADDR_DMA_CTL)
          s_axi_bresp <= LRS_RESP_OKAY;
        else
          s_axi_bresp <= LRS_RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // control registers written through byte lane 0
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      irq_en_q  <= LRS_IRQ_EN_RST;
      mode_q    <= LRS_MODE_RST;
      dma_ctl_q <= LRS_DMA_RST;
    end
    else if (ce && wr_go && wstrb_q[0])
    begin
      if (awaddr_q == LRS_ADDR_IRQ_EN)
        irq_en_q <= wdata_q[7:0];
      else if (awaddr_q == LRS_ADDR_MODE)
        mode_q <= wdata_q[3:0];
      else if (awaddr_q == LRS_ADDR_DMA_CTL)
        dma_ctl_q <= wdata_q[1:0];
    end
  end

  assign w1c = (wr_go && wstrb_q[0] && awaddr_q == LRS_ADDR_STATUS)
               ? wdata_q[7:0] : 8'h00;

  // read channel
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= LRS_RESP_OKAY;
    end
    else if (ce)
    begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= LRS_RESP_OKAY;
        if (s_axi_araddr == LRS_ADDR_STATUS)
          s_axi_rdata <= {24'h000000, flags};
        else if (s_axi_araddr == LRS_ADDR_IRQ_EN)
          s_axi_rdata <= {24'h000000, irq_en_q};
        else if (s_axi_araddr == LRS_ADDR_MODE)
          s_axi_rdata <= {28'h0000000, mode_q};
        else if (s_axi_araddr == LRS_ADDR_DMA_CTL)
          s_axi_rdata <= {30'h00000000, dma_ctl_q};
        else
        begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= LRS_RESP_SLVERR;
        end
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  lrs_rd_timeout #(
    .TMO_CYC (RD_TMO_CYC)
  ) u_tmo (
    .clk       (clk),
    .reset     (reset),
    .ce        (ce),
    .rd_req    (host_rd_req),
    .rd_rdy    (host_rd_rdy),
    .tmo_pulse (rd_tmo)
  );

  // flag set and clear events
  logic dma_off;
  logic rmt_ok;
  logic is_short;
  assign dma_off  = !dma_ctl_q[LRS_DMA_RX_EN] && !dma_ctl_q[LRS_DMA_TX_EN];
  assign is_short = rx_byte_count <= 11'(LRS_MIN_PKT_BYTES);
  assign rmt_ok   = rx_done && rx_len_field == LRS_REMOTE_RESET_FLAG_LEN
                    && mode_q[LRS_MODE_RMT_EN]
                    && rx_phys_match
                    && !mode_q[LRS_MODE_SHORT_EN];

  always_comb
  begin
    set_ev = 8'h00;
    clr_ev = w1c;
    // re-raised while buffer still holds packets
    set_ev[LRS_BIT_PACKET_READY_FLAG] = pkt_stored
                              || pkts_remaining;
    set_ev[LRS_BIT_RD_ERR]  = rd_tmo;
    // pc card mode has no dma handshake
    set_ev[LRS_BIT_DMA_END] = dma_end_flag
                              && !mode_q[LRS_MODE_PCCARD];
    clr_ev[LRS_BIT_DMA_END] = w1c[LRS_BIT_DMA_END]
                              || dma_off;
    set_ev[LRS_BIT_REMOTE_RESET_FLAG] = rmt_ok;
    clr_ev[LRS_BIT_REMOTE_RESET_FLAG] = w1c[LRS_BIT_REMOTE_RESET_FLAG] || rx_start;
    set_ev[LRS_BIT_SHORT]   = rx_done && is_short
                              && !rx_self_collision;
    set_ev[LRS_BIT_CRC]     = rx_done && rx_crc_bad
                              && !rx_self_collision;
    set_ev[LRS_BIT_ALIGN]   = rx_done && rx_crc_bad && rx_bits_odd;
    set_ev[LRS_BIT_OVFL]    = rx_discarded
                              && !mode_q[LRS_MODE_LOOPBACK];
    // rx_start marks a new packet; set from rx_done wins
    clr_ev[LRS_BIT_SHORT] = w1c[LRS_BIT_SHORT] || rx_start;
    clr_ev[LRS_BIT_ALIGN] = w1c[LRS_BIT_ALIGN] || rx_start;
    clr_ev[LRS_BIT_CRC]   = w1c[LRS_BIT_CRC] || rx_start;
    clr_ev[LRS_BIT_OVFL]  = w1c[LRS_BIT_OVFL] || rx_start;
  end

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_flag
      lrs_flag_bit u_bit (
        .clk    (clk),
        .reset  (reset),
        .ce     (ce),
        .set_i  (set_ev[gi]),
        .clr_i  (clr_ev[gi]),
        .flag_q (flags[gi])
      );
    end
  endgenerate

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      irq <= 1'b0;
    else if (ce)
      irq <= |(flags & irq_en_q);
  end

  // assertions
  property p_irq;
    @(posedge clk) disable iff (reset)
    ce |=> irq == |($past(flags) & $past(irq_en_q));
  endproperty
  a_irq: assert property (p_irq)
    else $error("irq does not follow enabled flags");

  property p_w1c_clears;
    @(posedge clk) disable iff (reset)
    ce && w1c[LRS_BIT_RD_ERR] && !set_ev[LRS_BIT_RD_ERR]
      |=> !flags[LRS_BIT_RD_ERR];
  endproperty
  a_w1c_clears: assert property (p_w1c_clears)
    else $error("write one did not clear flag");

  property p_set_wins;
    @(posedge clk) disable iff (reset)
    ce && set_ev[LRS_BIT_CRC] && clr_ev[LRS_BIT_CRC]
      |=> flags[LRS_BIT_CRC];
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("set lost against clear");

  property p_packet_ready_flag;
    @(posedge clk) disable iff (reset)
    ce && pkts_remaining |=> flags[LRS_BIT_PACKET_READY_FLAG];
  endproperty
  a_packet_ready_flag: assert property (p_packet_ready_flag)
    else $error("packet ready not reasserted");

  property p_dma_clr;
    @(posedge clk) disable iff (reset)
    ce && dma_off && !set_ev[LRS_BIT_DMA_END] |=> !flags[LRS_BIT_DMA_END];
  endproperty
  a_dma_clr: assert property (p_dma_clr)
    else $error("dma end not cleared with enables off");

  property p_rmt_short;
    @(posedge clk) disable iff (reset)
    ce && mode_q[LRS_MODE_SHORT_EN] && !flags[LRS_BIT_REMOTE_RESET_FLAG]
      |=> !flags[LRS_BIT_REMOTE_RESET_FLAG];
  endproperty
  a_rmt_short: assert property (p_rmt_short)
    else $error("remote reset set under short accept");

  property p_rmt_start;
    @(posedge clk) disable iff (reset)
    ce && rx_start && !rmt_ok |=> !flags[LRS_BIT_REMOTE_RESET_FLAG];
  endproperty
  a_rmt_start: assert property (p_rmt_start)
    else $error("remote reset kept at packet start");

  property p_ovfl_loop;
    @(posedge clk) disable iff (reset)
    ce && mode_q[LRS_MODE_LOOPBACK] && !flags[LRS_BIT_OVFL]
      |=> !flags[LRS_BIT_OVFL];
  endproperty
  a_ovfl_loop: assert property (p_ovfl_loop)
    else $error("overflow set in loopback");

  property p_rd_err;
    @(posedge clk) disable iff (reset)
    ce && rd_tmo |=> flags[LRS_BIT_RD_ERR];
  endproperty
  a_rd_err: assert property (p_rd_err)
    else $error("read error not raised on timeout");

  property p_pccard;
    @(posedge clk) disable iff (reset)
    ce && mode_q[LRS_MODE_PCCARD] && !flags[LRS_BIT_DMA_END]
      |=> !flags[LRS_BIT_DMA_END];
  endproperty
  a_pccard: assert property (p_pccard)
    else $error("dma end set in pc card mode");

  property p_new_pkt;
    @(posedge clk) disable iff (reset)
    ce && rx_start && !set_ev[LRS_BIT_OVFL] |=> !flags[LRS_BIT_OVFL];
  endproperty
  a_new_pkt: assert property (p_new_pkt)
    else $error("overflow kept at new packet");

  c_irq: cover property (@(posedge clk) disable iff (reset) $rose(irq));
  c_tmo: cover property (@(posedge clk) disable iff (reset) rd_tmo);
  c_rmt: cover property (@(posedge clk) disable iff (reset)
    set_ev[LRS_BIT_REMOTE_RESET_FLAG]);
  c_race: cover property (@(posedge clk) disable iff (reset)
    set_ev[LRS_BIT_CRC] && w1c[LRS_BIT_CRC]);

endmodule // lrs_status
`default_nettype wire

//--- common/lrs_pkg.sv
package lrs_pkg;

  // register byte addresses
  localparam logic [3:0] LRS_ADDR_STATUS  = 4'h0;
  localparam logic [3:0] LRS_ADDR_IRQ_EN  = 4'h4;
  localparam logic [3:0] LRS_ADDR_MODE    = 4'h8;
  localparam logic [3:0] LRS_ADDR_DMA_CTL = 4'hc;

  // flag positions in receive_status_flags
  localparam int LRS_BIT_PACKET_READY_FLAG = 7;
  localparam int LRS_BIT_RD_ERR  = 6;
  localparam int LRS_BIT_DMA_END = 5;
  localparam int LRS_BIT_REMOTE_RESET_FLAG = 4;
  localparam int LRS_BIT_SHORT   = 3;
  localparam int LRS_BIT_ALIGN   = 2;
  localparam int LRS_BIT_CRC     = 1;
  localparam int LRS_BIT_OVFL    = 0;

  // receive_mode_control_reg bits
  localparam int LRS_MODE_RMT_EN   = 0;
  localparam int LRS_MODE_SHORT_EN = 1;
  localparam int LRS_MODE_LOOPBACK = 2;
  localparam int LRS_MODE_PCCARD   = 3;
  // dma_enable_control_reg bits
  localparam int LRS_DMA_RX_EN = 0;
  localparam int LRS_DMA_TX_EN = 1;

  localparam logic [7:0] LRS_FLAGS_RST = 8'h00;
  localparam logic [7:0] LRS_IRQ_EN_RST = 8'h00;
  localparam logic [3:0] LRS_MODE_RST = 4'h0;
  localparam logic [1:0] LRS_DMA_RST = 2'h0;

  localparam logic [15:0] LRS_REMOTE_RESET_FLAG_LEN = 16'h0900;
  localparam int LRS_MIN_PKT_BYTES = 60;

  // read-ready timeout on the receive buffer port
  localparam int LRS_CLK_MHZ     = 200;
  localparam int LRS_RD_TMO_NS   = 2150;
  localparam int LRS_RD_TMO_CYC  = (LRS_RD_TMO_NS * LRS_CLK_MHZ) / 1000;

  localparam logic [1:0] LRS_RESP_OKAY   = 2'h0;
  localparam logic [1:0] LRS_RESP_SLVERR = 2'h2;

endpackage

//--- rtl/lrs_rd_timeout.sv
`timescale 1ns/1ps
`default_nettype none
// flags a host buffer read left without ready for the timeout period
module lrs_rd_timeout
  import lrs_pkg::*;
#(
  parameter int TMO_CYC = LRS_RD_TMO_CYC
)
(
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic ce,
  input  wire logic rd_req,
  input  wire logic rd_rdy,
  output logic      tmo_pulse
);

  logic [15:0] cnt_q;
  logic        fired_q;

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      cnt_q     <= 16'h0000;
      fired_q   <= 1'b0;
      tmo_pulse <= 1'b0;
    end
    else if (ce)
    begin
      tmo_pulse <= 1'b0;
      if (!rd_req || rd_rdy)
      begin
        cnt_q   <= 16'h0000;
        fired_q <= 1'b0;
      end
      else if (!fired_q)
      begin
        if (cnt_q == 16'(TMO_CYC - 1))
        begin
          tmo_pulse <= 1'b1;
          fired_q   <= 1'b1;
        end
        else
          cnt_q <= cnt_q + 16'h0001;
      end
    end
  end

endmodule // lrs_rd_timeout
`default_nettype wire

//--- rtl/lrs_flag_bit.sv
`timescale 1ns/1ps
`default_nettype none
// one sticky flag: set beats any clear in the same cycle
module lrs_flag_bit
(
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic ce,
  input  wire logic set_i,
  input  wire logic clr_i,
  output logic      flag_q
);

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      flag_q <= 1'b0;
    else if (ce)
    begin
      if (set_i)
        flag_q <= 1'b1;
      else if (clr_i)
        flag_q <= 1'b0;
    end
  end

endmodule // lrs_flag_bit
`default_nettype wire

//--- sim/lrs_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// host side: one write and one read at a time, no fixed latency assumed
module lrs_host_model
(
  input  wire logic        clk,
  output var  logic [3:0]  awaddr,
  output var  logic        awvalid,
  input  wire logic        awready,
  output var  logic [31:0] wdata,
  output var  logic [3:0]  wstrb,
  output var  logic        wvalid,
  input  wire logic        wready,
  input  wire logic [1:0]  bresp,
  input  wire logic        bvalid,
  output var  logic        bready,
  output var  logic [3:0]  araddr,
  output var  logic        arvalid,
  input  wire logic        arready,
  input  wire logic [31:0] rdata,
  input  wire logic [1:0]  rresp,
  input  wire logic        rvalid,
  output var  logic        rready
);
  initial
  begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready} = '0;
  end

  task automatic wr(logic [3:0] a, logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
    end
    while (awvalid || wvalid);
    while (!bvalid)
      @(posedge clk);
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(logic [3:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge clk); while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
endmodule // lrs_host_model
`default_nettype wire

//--- sim/lrs_status_tb.sv
`timescale 1ns/1ps
`default_nettype none
module lrs_status_tb
  import lrs_pkg::*;
;
  localparam int TMO = 8;
  logic        clk, reset, ce, irq;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [3:0]  awaddr, araddr, wstrb;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp;
  logic [1:0]  wr_resp;
  logic        pkt_stored, pkts_remaining, host_rd_req, host_rd_rdy;
  logic        dma_end_flag, rx_start, rx_done, rx_phys_match, rx_discarded;
  logic        rx_self_collision, rx_crc_bad, rx_bits_odd;
  logic [15:0] rx_len_field;
  logic [10:0] rx_byte_count;
  logic [7:0]  en;
  int          fail_count, checked;

  always #2.5 clk = ~clk;

  lrs_status #(.RD_TMO_CYC(TMO)) lrs_status_inst (
    .clk(clk), .reset(reset), .ce(ce),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .pkt_stored(pkt_stored), .pkts_remaining(pkts_remaining),
    .host_rd_req(host_rd_req), .host_rd_rdy(host_rd_rdy),
    .dma_end_flag(dma_end_flag), .rx_start(rx_start), .rx_done(rx_done),
    .rx_phys_match(rx_phys_match), .rx_len_field(rx_len_field),
    .rx_byte_count(rx_byte_count), .rx_self_collision(rx_self_collision),
    .rx_crc_bad(rx_crc_bad), .rx_bits_odd(rx_bits_odd),
    .rx_discarded(rx_discarded), .irq(irq));

  lrs_host_model lrs_host_model_inst (
    .clk(clk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready));

  task automatic close_out();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(string n, logic [31:0] s, logic [31:0] e);
    checked++;
    if (s !== e)
    begin
      fail_count++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic w(logic [3:0] a, logic [31:0] d);
    logic [1:0] r;
    lrs_host_model_inst.wr(a, d, r);
    chk("bresp", {30'h0, r}, {30'h0, LRS_RESP_OKAY});
  endtask

  task automatic rr(logic [3:0] a, logic [31:0] e, logic [1:0] er);
    logic [31:0] d;
    logic [1:0]  r;
    lrs_host_model_inst.rd(a, d, r);
    chk("rdata", d, e);
    chk("rresp", {30'h0, r}, {30'h0, er});
  endtask

  // status read also checks irq; irq has settled by the time data returns
  task automatic rs(logic [7:0] e);
    rr(LRS_ADDR_STATUS, {24'h0, e}, LRS_RESP_OKAY);
    chk("irq", {31'h0, irq}, {31'h0, (e & en) != 8'h00});
    w(LRS_ADDR_STATUS, {24'h0, e});
  endtask

  task automatic ev(int k);
    @(posedge clk);
    case (k)
      0: pkt_stored <= 1'b1;
      1: dma_end_flag <= 1'b1;
      2: rx_start <= 1'b1;
      4: {rx_start, rx_done} <= 2'b11;
      default: rx_discarded <= 1'b1;
    endcase
    @(posedge clk);
    {pkt_stored, dma_end_flag, rx_start, rx_discarded, rx_done} <= 5'h00;
  endtask

  task automatic rx(logic [15:0] l, logic [10:0] c, logic [3:0] q);
    @(posedge clk);
    rx_len_field <= l;
    rx_byte_count <= c;
    {rx_phys_match, rx_self_collision, rx_crc_bad, rx_bits_odd} <= q;
    rx_done <= 1'b1;
    @(posedge clk);
    rx_done <= 1'b0;
  endtask

  function automatic logic [10:0] big();
    return 11'($urandom_range(1500, LRS_MIN_PKT_BYTES + 1));
  endfunction

  initial
  begin
    repeat (20000) @(posedge clk);
    fail_count++;
    close_out();
  end

  initial
  begin
    {clk, ce, reset, en} = {3'b011, 8'h00};
    {pkt_stored, pkts_remaining, host_rd_req, host_rd_rdy} = 4'h0;
    {dma_end_flag, rx_start, rx_done, rx_discarded} = 4'h0;
    {rx_phys_match, rx_self_collision, rx_crc_bad, rx_bits_odd} = 4'h0;
    {rx_len_field, rx_byte_count} = '0;
    void'($urandom(32'h7a5c43d6));
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    rs(8'h00);
    for (int i = 0; i < 3; i++)
    begin
      en = (i == 2) ? 8'hff : 8'($urandom);
      w(LRS_ADDR_IRQ_EN, {24'h0, en});
      rr(LRS_ADDR_IRQ_EN, {24'h0, en}, LRS_RESP_OKAY);
      w(LRS_ADDR_MODE, 32'h1);
      w(LRS_ADDR_DMA_CTL, 32'h1);
      rr(LRS_ADDR_DMA_CTL, 32'h1, LRS_RESP_OKAY);
      ev(0);
      rs(8'h80);
      host_rd_req <= 1'b1;
      repeat (TMO - 2) @(posedge clk);
      host_rd_rdy <= 1'b1;
      @(posedge clk);
      {host_rd_req, host_rd_rdy} <= 2'b00;
      rs(8'h00);
      host_rd_req <= 1'b1;
      repeat (TMO + 3) @(posedge clk);
      host_rd_req <= 1'b0;
      rs(8'h40);
      ev(1);
      w(LRS_ADDR_STATUS, 32'h0);
      rs(8'h20);
      ev(1);
      w(LRS_ADDR_DMA_CTL, 32'h0);
      rs(8'h00);
      w(LRS_ADDR_DMA_CTL, 32'h2);
      w(LRS_ADDR_MODE, 32'h9);
      rr(LRS_ADDR_MODE, 32'h9, LRS_RESP_OKAY);
      ev(1);
      rs(8'h00);
      w(LRS_ADDR_MODE, 32'h1);
      rx(LRS_REMOTE_RESET_FLAG_LEN, big(), 4'h8);
      ev(2);
      rs(8'h00);
      rx(LRS_REMOTE_RESET_FLAG_LEN, big(), 4'h8);
      rs(8'h10);
      rx(LRS_REMOTE_RESET_FLAG_LEN, big(), 4'h0);
      rs(8'h00);
      w(LRS_ADDR_MODE, 32'h3);
      rx(LRS_REMOTE_RESET_FLAG_LEN, big(), 4'h8);
      rs(8'h00);
      rx(16'h0040, 11'($urandom_range(60, 1)), 4'h8);
      rs(8'h08);
      rx(16'h0040, 11'd61, 4'h8);
      rx(16'h0040, 11'd40, 4'hc);
      rs(8'h00);
      rx(16'h0800, big(), 4'h2);
      rs(8'h02);
      rx(16'h0800, big(), 4'h1);
      rs(8'h00);
      rx(16'h0800, 11'd60, 4'hb);
      rs(8'h0e);
      rx(16'h0800, 11'd60, 4'ha);
      ev(3);
      ev(2);
      rs(8'h00);
      // packet end and next start in one cycle: the sets must win
      ev(4);
      rs(8'h0a);
      ev(3);
      rs(8'h01);
      w(LRS_ADDR_MODE, 32'h5);
      ev(3);
      rs(8'h00);
      pkts_remaining <= 1'b1;
      ev(0);
      rs(8'h80);
      pkts_remaining <= 1'b0;
      rs(8'h80);
      rs(8'h00);
    end
    // events while ce is low must be lost
    ce <= 1'b0;
    ev(0);
    ce <= 1'b1;
    rs(8'h00);
    ev(1);
    lrs_host_model_inst.wr(4'h2, 32'hff, wr_resp);
    chk("bresp", {30'h0, wr_resp}, {30'h0, LRS_RESP_SLVERR});
    rs(8'h20);
    rr(4'h6, 32'h0, LRS_RESP_SLVERR);
    // second reset in mid-run clears flags and enables
    ev(1);
    reset <= 1'b1;
    @(posedge clk);
    reset <= 1'b0;
    rs(8'h00);
    rr(LRS_ADDR_IRQ_EN, {24'h0, LRS_IRQ_EN_RST}, LRS_RESP_OKAY);
    close_out();
  end
endmodule // lrs_status_tb
`default_nettype wire
